// *** dv/instruction_prefetch_queue_test.sv ***
// self-checking bench of the prefetch queue with a memory model on its bus
// assumes the model waits 0..3 cycles by address bits 9:8
`timescale 1ns/1ps
`default_nettype none
module instruction_prefetch_queue_test;
    import ipq_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, eu_pop = 1'b0, eu_flush = 1'b0, du_req = 1'b0;
    logic [2:0] eu_need = 3'h0;
    ipq_addr_t  eu_new_pc = 20'h00000;
    ipq_dreq_s  du_cmd = '0;
    logic [7:0] bus_rdata, q_head;
    ipq_wait_t  bus_wait;
    logic [2:0] q_count;
    logic       eu_stall, du_done;
    logic [15:0] du_rdata;
    ipq_bus_s   bus;
    int         mismatches = 0, samples_checked = 0, cycles = 0;

    ipq_prefetch_queue ipq_prefetch_queue_i (.clk(clk), .rst_n(rst_n), .eu_need(eu_need), .eu_pop(eu_pop),
        .eu_flush(eu_flush), .eu_new_pc(eu_new_pc), .du_req(du_req), .du_cmd(du_cmd), .bus_rdata(bus_rdata),
        .bus_wait(bus_wait), .q_head(q_head), .q_count(q_count), .eu_stall(eu_stall), .du_done(du_done),
        .du_rdata(du_rdata), .bus(bus));
    ipq_mem_model ipq_mem_model_i (.clk(clk), .bus(bus), .bus_rdata(bus_rdata), .bus_wait(bus_wait));

    always #12.5 clk = ~clk;

    task automatic final_report();
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] mem_byte(input ipq_addr_t a);
        return a[7:0] ^ 8'h5A;
    endfunction : mem_byte

    task automatic full_queue(input ipq_addr_t pc);
        repeat (200)
            if (q_count !== 3'h4)
                @(negedge clk);
        check(q_count, 3'h4);
        check(q_head, mem_byte(pc));
        repeat (6)
        begin
            @(negedge clk);
            check(bus.act, 1'b0);
        end
    endtask : full_queue

    // back-to-back pops while refill runs behind them
    task automatic pop_run(input ipq_addr_t pc);
        for (int i = 0; i < 4; i++)
        begin
            check(q_head, mem_byte(pc + 20'(i)));
            eu_pop = 1'b1;
            @(negedge clk);
        end
        eu_pop = 1'b0;
    endtask : pop_run

    task automatic flush_to(input ipq_addr_t pc);
        int n;
        eu_new_pc = pc;
        eu_flush = 1'b1;
        eu_need = 3'h3;
        @(negedge clk);
        eu_flush = 1'b0;
        check(q_count, 3'h0);
        @(negedge clk);
        check(eu_stall, 1'b1);
        repeat (40)
            if (!(bus.act === 1'b1 && bus.addr === pc))
                @(negedge clk);
        check(bus.addr, pc);
        n = 0;
        while (bus.act === 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        check(20'(n), 20'(1 + pc[9:8]));
        full_queue(pc);
        check(eu_stall, 1'b0);
        eu_need = 3'h0;
        pop_run(pc);
    endtask : flush_to

    // starts in the next idle bus cycle; a prefetch is pending then only if the queue has room
    task automatic data(input logic we, input logic wide, input ipq_addr_t a, input logic [15:0] wd,
                        input logic [15:0] ex);
        int n;
        @(negedge clk);
        repeat (40)
            if (bus.act !== 1'b0)
                @(negedge clk);
        du_cmd = '{we: we, wide: wide, addr: a, wdata: wd};
        du_req = 1'b1;
        @(negedge clk);
        check(bus.code, 1'b0);
        check(bus.addr, a);
        n = 1;
        while (du_done !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        du_req = 1'b0;
        check(20'(n), wide ? 20'(3 + 2 * a[9:8]) : 20'(2 + a[9:8]));
        if (!we)
            check(20'(du_rdata), 20'(ex));
    endtask : data

    // reset in mid-run clears everything and restarts fetching at the reset address
    task automatic reset_run();
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check(q_count, 3'h0);
        check(bus.act, 1'b0);
        check(eu_stall, 1'b0);
        check(du_done, 1'b0);
        check(du_rdata, 16'h0000);
        rst_n = 1'b1;
        @(negedge clk);
        check(bus.act & bus.code, 1'b1);
        check(bus.addr, 20'h00000);
        full_queue(20'h00000);
    endtask : reset_run

    initial
    begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        full_queue(20'h00000);
        pop_run(20'h00000);
        flush_to(20'h00300);
        flush_to(20'h00000);
        data(1'b1, 1'b1, 20'h00104, 16'hC3E1, 16'h0000);
        data(1'b0, 1'b1, 20'h00104, 16'h0000, 16'hC3E1);
        data(1'b0, 1'b0, 20'h00105, 16'h0000, 16'h00C3);
        data(1'b0, 1'b0, 20'h00000, 16'h0000, 16'h005A);
        data(1'b1, 1'b0, 20'h002F0, 16'h0077, 16'h0000);
        data(1'b0, 1'b0, 20'h002F0, 16'h0000, 16'h0077);
        reset_run();
        final_report();
    end
endmodule : instruction_prefetch_queue_test
`default_nettype wire

// *** dv/ipq_mem_model.sv ***
// memory model on the internal bus: byte array, waits by address region
// assumes bus outputs registered by the queue block
`timescale 1ns/1ps
`default_nettype none
module ipq_mem_model
    import ipq_pkg::*;
(
    input  wire logic     clk,
    input  wire ipq_bus_s bus,
    output logic [7:0]    bus_rdata,
    output ipq_wait_t     bus_wait
);
    logic [7:0] mem_r [0:1023];
    logic [7:0] last_r;
    initial
    begin
        last_r = 8'h00;
        for (int i = 0; i < 1024; i++)
            mem_r[i] = 8'(i) ^ 8'h5A;
    end
    // region waits 0..3 from address bits 9:8
    assign bus_wait  = {2'b00, bus.addr[9:8]};
    // idle bus shows the inverse of the last byte, never a stale match
    assign bus_rdata = (bus.act && !bus.we) ? mem_r[bus.addr[9:0]] : ~last_r;
    always @(posedge clk)
    begin
        if (bus.act && bus.we)
            mem_r[bus.addr[9:0]] <= bus.wdata;
        if (bus.act && !bus.we)
            last_r <= mem_r[bus.addr[9:0]];
    end
endmodule : ipq_mem_model
`default_nettype wire

// *** rtl/ipq_defines.svh ***
// constants of the instruction prefetch queue: sizes, levels, reset values
// assumes inclusion by bare name from the package and the design module
`ifndef IPQ_DEFINES_SVH
`define IPQ_DEFINES_SVH

`define IPQ_DEPTH      4
`define IPQ_FULL_LVL   3'h3
`define IPQ_ADDR_W     20
`define IPQ_WAIT_W     4
`define IPQ_RST_PC     20'h00000
`define IPQ_RST_BYTE   8'h00

`endif

// *** rtl/ipq_pkg.sv ***
// types of the instruction prefetch queue
// assumes ipq_defines.svh on the include path
`include "ipq_defines.svh"

package ipq_pkg;

    typedef enum logic [2:0] {
        IPQ_ST_IDLE = 3'b001,
        IPQ_ST_CODE = 3'b010,
        IPQ_ST_DATA = 3'b100
    } ipq_state_e;

    typedef logic [`IPQ_ADDR_W-1:0] ipq_addr_t;
    typedef logic [`IPQ_WAIT_W-1:0] ipq_wait_t;

    // data access request of the execution unit
    typedef struct packed {
        logic        we;
        logic        wide;
        ipq_addr_t   addr;
        logic [15:0] wdata;
    } ipq_dreq_s;

    // one byte-wide internal bus cycle
    typedef struct packed {
        logic      act;
        logic      code;
        logic      we;
        ipq_addr_t addr;
        logic [7:0] wdata;
    } ipq_bus_s;

    typedef struct packed {
        ipq_state_e                  state;
        logic [`IPQ_DEPTH-1:0][7:0]  q;
        logic [2:0]                  cnt;
        ipq_addr_t                   fpc;
        logic                        drop;
        logic                        first;
        ipq_wait_t                   wcnt;
        logic                        hi;
        ipq_dreq_s                   dreq;
        logic [15:0]                 rdata;
        logic                        done;
        logic                        stall;
        ipq_bus_s                    bus;
    } ipq_state_s;

endpackage : ipq_pkg

// *** rtl/ipq_prefetch_queue.sv ***
// instruction prefetch queue and internal bus arbitration of a 16-bit cpu core
// assumes one clock, bus inputs synchronous, bus_wait giving the waits of the addressed region
// How it works
// - a queue of four one-byte entries holds prefetched code ahead of execution.
// - whenever the queue has room, the bus is idle and no data request or flush is pending, the next code byte is read into it.
// - execution pops bytes and is told to stall while fewer bytes than it needs are queued.
// - a code fetch lasts one cycle plus exactly the waits of its region.
// - each byte of a data read or write lasts one cycle plus exactly the waits of its region.
// - a 16-bit data transfer is done as two consecutive byte accesses, low byte first.
// - a data request and a prefetch in the same cycle give the bus to the data request.
// - with more than three bytes queued no prefetch starts.
// - only single-byte data without waits and fully queued code keep nominal cycle counts.
`timescale 1ns/1ps
`default_nettype none
`include "ipq_defines.svh"

module ipq_prefetch_queue
    import ipq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] eu_need,
    input  wire logic       eu_pop,
    input  wire logic       eu_flush,
    input  wire ipq_addr_t  eu_new_pc,
    input  wire logic       du_req,
    input  wire ipq_dreq_s  du_cmd,
    input  wire logic [7:0] bus_rdata,
    input  wire ipq_wait_t  bus_wait,
    output logic [7:0]      q_head,
    output logic [2:0]      q_count,
    output logic            eu_stall,
    output logic            du_done,
    output logic [15:0]     du_rdata,
    output ipq_bus_s        bus
);

    ipq_state_s s_r;
    ipq_state_s s_nxt;
    ipq_wait_t  w_eff;
    logic       in_acc;
    logic       acc_end;
    logic       take_data;
    logic       start_code;
    logic       pop;

    // waits are sampled on the first cycle of each byte access
    assign w_eff      = s_r.first ? bus_wait : s_r.wcnt;
    assign in_acc     = s_r.state != IPQ_ST_IDLE;
    assign acc_end    = in_acc && (w_eff == '0);
    // done blocks a retake while the requester still holds du_req
    assign take_data  = (s_r.state == IPQ_ST_IDLE) && du_req && !s_r.done;
    assign start_code = (s_r.state == IPQ_ST_IDLE) && !take_data && !eu_flush
                        && (s_r.cnt <= `IPQ_FULL_LVL);
    assign pop        = eu_pop && (s_r.cnt != 3'h0);

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (pop)
        begin
            s_nxt.q   = s_r.q >> 8;
            s_nxt.cnt = s_r.cnt - 3'h1;
        end
        if (in_acc && !acc_end)
        begin
            s_nxt.wcnt  = w_eff - 4'h1;
            s_nxt.first = 1'b0;
        end
        else if (in_acc && s_r.state == IPQ_ST_CODE)
        begin
            s_nxt.bus.act = 1'b0;
            s_nxt.state   = IPQ_ST_IDLE;
            s_nxt.drop    = 1'b0;
            // a fetch that straddles a flush still finishes, its byte is dropped
            if (!s_r.drop && !eu_flush)
            begin
                s_nxt.q[s_nxt.cnt[1:0]] = bus_rdata;
                s_nxt.cnt               = s_nxt.cnt + 3'h1;
                s_nxt.fpc               = s_r.fpc + 20'h1;
            end
        end
        else if (in_acc && s_r.dreq.wide && !s_r.hi)
        begin
            if (!s_r.dreq.we)
                s_nxt.rdata[7:0] = bus_rdata;
            s_nxt.hi        = 1'b1;
            s_nxt.first     = 1'b1;
            s_nxt.bus.addr  = s_r.bus.addr + 20'h1;
            s_nxt.bus.wdata = s_r.dreq.wdata[15:8];
        end
        else if (in_acc)
        begin
            if (!s_r.dreq.we && s_r.hi)
                s_nxt.rdata[15:8] = bus_rdata;
            else if (!s_r.dreq.we)
                s_nxt.rdata = {8'h00, bus_rdata};
            s_nxt.done    = 1'b1;
            s_nxt.bus.act = 1'b0;
            s_nxt.state   = IPQ_ST_IDLE;
        end
        else if (take_data)
        begin
            s_nxt.state = IPQ_ST_DATA;
            s_nxt.dreq  = du_cmd;
            s_nxt.hi    = 1'b0;
            s_nxt.first = 1'b1;
            s_nxt.bus   = '{act: 1'b1, code: 1'b0, we: du_cmd.we, addr: du_cmd.addr, wdata: du_cmd.wdata[7:0]};
        end
        else if (start_code)
        begin
            s_nxt.state = IPQ_ST_CODE;
            s_nxt.first = 1'b1;
            s_nxt.bus   = '{act: 1'b1, code: 1'b1, we: 1'b0, addr: s_r.fpc, wdata: `IPQ_RST_BYTE};
        end
        if (eu_flush)
        begin
            s_nxt.cnt  = 3'h0;
            s_nxt.fpc  = eu_new_pc;
            s_nxt.drop = (s_r.state == IPQ_ST_CODE) && !acc_end;
        end
        // stall whenever the bytes needed are not yet all queued
        s_nxt.stall = eu_need > s_nxt.cnt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r       <= '0;
            s_r.state <= IPQ_ST_IDLE;
            s_r.fpc   <= `IPQ_RST_PC;
        end
        else
            s_r <= s_nxt;
    end

    assign q_head   = s_r.q[0];
    assign q_count  = s_r.cnt;
    assign eu_stall = s_r.stall;
    assign du_done  = s_r.done;
    assign du_rdata = s_r.rdata;
    assign bus      = s_r.bus;

    // helpers for the checks: cycle index within a byte access and its captured waits
    ipq_wait_t len_r;
    ipq_wait_t wcap_r;
    ipq_wait_t cur_len;
    ipq_wait_t cur_cap;
    assign cur_len = s_r.first ? 4'h0 : len_r;
    assign cur_cap = s_r.first ? bus_wait : wcap_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_r  <= '0;
            wcap_r <= '0;
        end
        else
        begin
            len_r  <= cur_len + 4'h1;
            wcap_r <= cur_cap;
        end
    end

    sequence s_code_end;
        acc_end && s_r.state == IPQ_ST_CODE;
    endsequence

    sequence s_low_half_end;
        acc_end && s_r.state == IPQ_ST_DATA && s_r.dreq.wide && !s_r.hi;
    endsequence

    // fetched byte lands in an empty queue, nothing popped or flushed alongside
    sequence s_push_to_empty;
        acc_end && s_r.state == IPQ_ST_CODE && !s_r.drop && !eu_flush && !pop && q_count == 3'h0;
    endsequence

    property p_depth;
        @(posedge clk) disable iff (!rst_n) q_count <= 3'h4;
    endproperty
    a_depth: assert property (p_depth) else $error("queue count above four");

    property p_prefetch;
        @(posedge clk) disable iff (!rst_n)
            (s_r.state == IPQ_ST_IDLE && !du_req && !eu_flush && q_count < 3'h4) |=> (bus.act && bus.code);
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("idle bus with room did not prefetch");

    property p_stall;
        @(posedge clk) disable iff (!rst_n) eu_stall == ($past(eu_need) > q_count);
    endproperty
    a_stall: assert property (p_stall) else $error("stall does not match queued bytes");

    property p_code_len;
        @(posedge clk) disable iff (!rst_n) s_code_end |-> cur_len == cur_cap;
    endproperty
    a_code_len: assert property (p_code_len) else $error("code fetch length differs from waits");

    property p_data_len;
        @(posedge clk) disable iff (!rst_n)
            (acc_end && s_r.state == IPQ_ST_DATA) |-> cur_len == cur_cap && bus.act;
    endproperty
    a_data_len: assert property (p_data_len) else $error("data access length differs from waits");

    property p_wide_split;
        @(posedge clk) disable iff (!rst_n)
            s_low_half_end |=> bus.act && !bus.code && bus.addr == $past(bus.addr) + 20'h1 && !du_done;
    endproperty
    a_wide_split: assert property (p_wide_split) else $error("16-bit transfer not split in two");

    property p_data_first;
        @(posedge clk) disable iff (!rst_n)
            (s_r.state == IPQ_ST_IDLE && du_req && !du_done) |=> bus.act && !bus.code;
    endproperty
    a_data_first: assert property (p_data_first) else $error("prefetch won over data access");

    property p_full;
        @(posedge clk) disable iff (!rst_n)
            (s_r.state == IPQ_ST_IDLE && q_count == 3'h4) |=> !(bus.act && bus.code);
    endproperty
    a_full: assert property (p_full) else $error("prefetch started on a full queue");

    property p_flush;
        @(posedge clk) disable iff (!rst_n) eu_flush |=> q_count == 3'h0 ##1 q_count <= 3'h1;
    endproperty
    a_flush: assert property (p_flush) else $error("flush left bytes queued");

    property p_order;
        @(posedge clk) disable iff (!rst_n)
            s_push_to_empty |=> q_head == $past(bus_rdata);
    endproperty
    a_order: assert property (p_order) else $error("fetched byte not at queue head");

endmodule : ipq_prefetch_queue

`default_nettype wire
